/* logic/ufmr_pkg.sv */
// types of the write-only bus receiver
`default_nettype none
package ufmr_pkg;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_ADDR  = 3'b001,
        S_DATA  = 3'b010,
        S_SW1   = 3'b011,
        S_SW2   = 3'b100,
        S_SWARM = 3'b101,
        S_SKIP  = 3'b110
    } ufmr_state_e;

endpackage
`default_nettype wire

/* logic/ufmr_regs.svh */
// constants of the write-only bus receiver
`ifndef UFMR_REGS_SVH
`define UFMR_REGS_SVH

`define UFMR_RST_CALL_ADDR 7'h03
`define UFMR_RST_CALL_BYTE1 8'hA5
`define UFMR_RST_CALL_BYTE2 8'h5A
`define UFMR_WRITE_BIT 1'b0
`define UFMR_LAST_DATA_BIT 4'h7
`define UFMR_ACK_SLOT 4'h8
`define UFMR_CNT_RESET 4'h0
`define UFMR_BYTE_RESET 8'h00
`define UFMR_LINE_IDLE 1'b1
`define UFMR_PULSE_RESET 1'b0

`endif

/* logic/ufmr_rx.sv */
// write-only bus receiver: framing, address match, byte stream, reset call
`timescale 1ns/1ps
`default_nettype none
`include "ufmr_regs.svh"

module ufmr_rx (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic usda_pin,
    input wire logic uscl_pin,
    input wire logic [6:0] own_addr,
    input wire logic [7:0] sub_addr1,
    input wire logic [7:0] sub_addr2,
    input wire logic [7:0] sub_addr3,
    input wire logic [7:0] all_call_addr,
    input wire logic [2:0] sub_address_enable,
    input wire logic all_call_enable,
    output logic [7:0] rx_data_r,
    output logic rx_valid_r,
    output logic rx_ctrl_r,
    output logic msg_start_r,
    output logic msg_stop_r,
    output logic soft_reset_call_r,
    output logic bus_idle_r
);
    import ufmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // line sampling

    logic [1:0] lines_s;
    logic scl_s;
    logic sda_s;
    logic scl_q_r;
    logic sda_q_r;

    // only inputs exist for the bus; no driver on the data line
    ufmr_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({uscl_pin, usda_pin}),
        .sync_out(lines_s)
    );

    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q_r <= `UFMR_LINE_IDLE;
            sda_q_r <= `UFMR_LINE_IDLE;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conditions and address decode

    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] stored, input logic en);
        addr_hit = en && (b[7:1] == stored[7:1]) && (b[0] == `UFMR_WRITE_BIT);
    endfunction

    ufmr_state_e state_r;
    ufmr_state_e state_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic [7:0] shift_r;
    logic ctrl_pend_r;

    wire scl_rise = scl_s && !scl_q_r;
    wire start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
    wire stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;
    wire framing = state_r != S_IDLE;
    wire bit_take = scl_rise && framing && !start_det && !stop_det;
    wire ack_slot = bit_cnt_r == `UFMR_ACK_SLOT;
    wire byte_done = bit_take && (bit_cnt_r == `UFMR_LAST_DATA_BIT);
    wire [7:0] new_byte = {shift_r[6:0], sda_s};
    wire hit_own = addr_hit(new_byte, {own_addr, `UFMR_WRITE_BIT}, 1'b1);
    wire hit_sub = addr_hit(new_byte, sub_addr1, sub_address_enable[0])
                || addr_hit(new_byte, sub_addr2, sub_address_enable[1])
                || addr_hit(new_byte, sub_addr3, sub_address_enable[2]);
    wire hit_all = addr_hit(new_byte, all_call_addr, all_call_enable);
    wire hit_any = hit_own || hit_sub || hit_all;
    wire hit_rst_call = new_byte == {`UFMR_RST_CALL_ADDR, `UFMR_WRITE_BIT};
    wire emit = byte_done && (state_r == S_DATA);
    wire accept = byte_done && (state_r == S_ADDR) && !hit_rst_call && hit_any;

    // ninth pulse closes the byte and its bit is dropped
    assign bit_cnt_nxt = (start_det || stop_det) ? `UFMR_CNT_RESET :
                         !bit_take ? bit_cnt_r :
                         ack_slot ? `UFMR_CNT_RESET :
                         4'(bit_cnt_r + 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // message state machine

    always_comb begin
        state_nxt = state_r;
        if (start_det) begin
            state_nxt = S_ADDR;
        end else if (stop_det) begin
            state_nxt = S_IDLE;
        end else if (byte_done) begin
            case (state_r)
                S_ADDR: begin
                    if (hit_rst_call) begin
                        state_nxt = S_SW1;
                    end else if (hit_any) begin
                        state_nxt = S_DATA;
                    end else begin
                        state_nxt = S_SKIP;
                    end
                end
                S_SW1: begin
                    state_nxt = (new_byte == `UFMR_RST_CALL_BYTE1) ? S_SW2 : S_SKIP;
                end
                S_SW2: begin
                    state_nxt = (new_byte == `UFMR_RST_CALL_BYTE2) ? S_SWARM : S_SKIP;
                end
                S_DATA: begin
                    state_nxt = S_DATA;
                end
                S_SWARM: begin
                    state_nxt = S_SWARM;
                end
                S_SKIP: begin
                    state_nxt = S_SKIP;
                end
                default: begin
                    state_nxt = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            bit_cnt_r <= `UFMR_CNT_RESET;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_r <= `UFMR_BYTE_RESET;
        end else if (bit_take && !ack_slot) begin
            shift_r <= new_byte;
        end
    end

    // first byte after the address is the control byte
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_pend_r <= `UFMR_PULSE_RESET;
        end else if (accept) begin
            ctrl_pend_r <= 1'b1;
        end else if (emit || start_det) begin
            ctrl_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_data_r <= `UFMR_BYTE_RESET;
            rx_valid_r <= `UFMR_PULSE_RESET;
            rx_ctrl_r <= `UFMR_PULSE_RESET;
            msg_start_r <= `UFMR_PULSE_RESET;
            msg_stop_r <= `UFMR_PULSE_RESET;
            soft_reset_call_r <= `UFMR_PULSE_RESET;
            bus_idle_r <= `UFMR_LINE_IDLE;
        end else begin
            rx_valid_r <= emit;
            rx_ctrl_r <= emit && ctrl_pend_r;
            if (emit) begin
                rx_data_r <= new_byte;
            end
            msg_start_r <= accept;
            msg_stop_r <= (stop_det || start_det) && (state_r == S_DATA);
            soft_reset_call_r <= stop_det && (state_r == S_SWARM);
            bus_idle_r <= (state_nxt == S_IDLE) && scl_s && sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_stop_closes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop_det |=> state_r == S_IDLE && bit_cnt_r == `UFMR_CNT_RESET)
        else $error("stop did not return receiver to idle");

    a_start_reframes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start_det |=> state_r == S_ADDR && bit_cnt_r == `UFMR_CNT_RESET)
        else $error("start did not restart byte framing");

    a_ninth_dropped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bit_take && ack_slot |=> bit_cnt_r == `UFMR_CNT_RESET && $stable(shift_r))
        else $error("ninth bit was not ignored");

    a_bit_per_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !scl_rise |=> $stable(shift_r))
        else $error("data shifted without a clock rising edge");

    a_byte_emitted: assert property (@(posedge clk_sys) disable iff (!rst_n)
        emit |=> rx_valid_r && rx_data_r == $past(new_byte) && state_r == S_DATA)
        else $error("data byte not delivered or message closed early");

    a_reset_call: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset_call_r |-> $past(stop_det) && $past(state_r) == S_SWARM)
        else $error("reset call pulse without full sequence and stop");

    a_addr_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byte_done && state_r == S_ADDR && !hit_any |=> state_r != S_DATA && !msg_start_r)
        else $error("unmatched or disabled address accepted");

    a_ctrl_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept ##1 (!start_det && !stop_det && !emit)[*1] |-> ctrl_pend_r)
        else $error("control byte marker lost after address");

    a_idle_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_IDLE && !start_det && scl_s && sda_s |=> bus_idle_r)
        else $error("idle bus not reported");

    a_no_idle_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus_idle_r |-> state_r == S_IDLE)
        else $error("idle reported while framing");
endmodule
`default_nettype wire

/* logic/ufmr_sync.sv */
// two-flop synchroniser for the bus lines
`timescale 1ns/1ps
`default_nettype none
`include "ufmr_regs.svh"

module ufmr_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // lines reset to their idle level
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_r <= {W{`UFMR_LINE_IDLE}};
            sync_out <= {W{`UFMR_LINE_IDLE}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench of the receive-only bus front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    logic clk_sys = 1'b0;
    logic rst_n;
    wire logic usda_w;
    wire logic uscl_w;
    logic [6:0] own_addr;
    logic [7:0] sub_addr1, sub_addr2, sub_addr3, all_call_addr;
    logic [2:0] sub_address_enable;
    logic all_call_enable;
    wire logic [7:0] rx_data_r;
    wire logic rx_valid_r, rx_ctrl_r, msg_start_r, msg_stop_r, soft_reset_call_r, bus_idle_r;
    int seed = 32'h0067;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] n_start, n_stop, n_rst, n_ctrl;
    logic [7:0] got_q[$];
    logic [7:0] tx_q[$];

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    ufmr_host host (.usda(usda_w), .uscl(uscl_w));

    ufmr_rx uut (.clk_sys(clk_sys), .rst_n(rst_n), .usda_pin(usda_w), .uscl_pin(uscl_w),
        .own_addr(own_addr), .sub_addr1(sub_addr1), .sub_addr2(sub_addr2), .sub_addr3(sub_addr3),
        .all_call_addr(all_call_addr), .sub_address_enable(sub_address_enable),
        .all_call_enable(all_call_enable), .rx_data_r(rx_data_r), .rx_valid_r(rx_valid_r),
        .rx_ctrl_r(rx_ctrl_r), .msg_start_r(msg_start_r), .msg_stop_r(msg_stop_r),
        .soft_reset_call_r(soft_reset_call_r), .bus_idle_r(bus_idle_r));

    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // pulse monitor and hang guard, sampled away from the launching edge
    always @(negedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end else if (rst_n === 1'b1) begin
            if (rx_valid_r === 1'b1) got_q.push_back(rx_data_r);
            n_ctrl = n_ctrl + rx_ctrl_r;
            n_start = n_start + msg_start_r;
            n_stop = n_stop + msg_stop_r;
            n_rst = n_rst + soft_reset_call_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic accepts(input logic [7:0] a);
        return !a[0] && a[7:1] != 7'h03 && (a[7:1] == own_addr
            || (sub_address_enable[0] && a[7:1] == sub_addr1[7:1])
            || (sub_address_enable[1] && a[7:1] == sub_addr2[7:1])
            || (sub_address_enable[2] && a[7:1] == sub_addr3[7:1])
            || (all_call_enable && a[7:1] == all_call_addr[7:1]));
    endfunction

    task automatic rand_cfg();
        own_addr = {1'b1, 6'($random(seed))};
        sub_addr1 = 8'($random(seed));
        sub_addr2 = 8'($random(seed));
        sub_addr3 = 8'($random(seed));
        all_call_addr = 8'($random(seed));
        sub_address_enable = 3'($random(seed));
        all_call_enable = 1'($random(seed));
    endtask

    task automatic fill(input int n);
        tx_q.delete();
        repeat (n) tx_q.push_back(8'($random(seed)));
    endtask

    task automatic clear();
        n_start = 8'h00;
        n_stop = 8'h00;
        n_rst = 8'h00;
        n_ctrl = 8'h00;
        got_q.delete();
    endtask

    task automatic xfer(input logic [7:0] a, input logic [7:0] exp_rst);
        logic acc;
        acc = accepts(a);
        clear();
        host.start_cond();
        @(negedge clk_sys);
        `CHK(bus_idle_r, 1'b0)
        host.put_byte(a);
        foreach (tx_q[i]) host.put_byte(tx_q[i]);
        host.stop_cond();
        repeat (8) @(negedge clk_sys);
        `CHK(n_start, {7'h00, acc})
        `CHK(n_stop, {7'h00, acc})
        `CHK(n_rst, exp_rst)
        `CHK(n_ctrl, {7'h00, acc && tx_q.size() > 0})
        `CHK(got_q.size(), acc ? tx_q.size() : 0)
        if (acc) foreach (tx_q[i]) `CHK(got_q[i], tx_q[i])
        `CHK(bus_idle_r, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a;
        rst_n = 1'b0;
        rand_cfg();
        clear();
        repeat (6) @(negedge clk_sys);
        `CHK(rx_data_r, 8'h00)
        `CHK(bus_idle_r, 1'b1)
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (int k = 0; k < 3; k++) begin
            fill(k == 0 ? 1 : (k == 1 ? 3 : 20));
            xfer({own_addr, 1'b0}, 8'h00);
        end
        xfer({own_addr, 1'b1}, 8'h00);
        for (int t = 0; t < 12; t++) begin
            rand_cfg();
            case ($unsigned($random(seed)) % 6)
                0: a = {own_addr, 1'b0};
                1: a = {sub_addr1[7:1], 1'b0};
                2: a = {sub_addr2[7:1], 1'b0};
                3: a = {sub_addr3[7:1], 1'b0};
                4: a = {all_call_addr[7:1], 1'b0};
                default: a = 8'($random(seed));
            endcase
            fill(1 + $unsigned($random(seed)) % 4);
            xfer(a, 8'h00);
        end
        tx_q = '{8'hA5, 8'h5A, 8'h33};
        xfer(8'h06, 8'h01);
        tx_q = '{8'hA5, 8'h5B};
        xfer(8'h06, 8'h00);
        // byte cut short by a stop is dropped
        clear();
        host.start_cond();
        host.put_byte({own_addr, 1'b0});
        for (int i = 0; i < 4; i++) host.put_bit(1'b0);
        host.stop_cond();
        repeat (8) @(negedge clk_sys);
        `CHK(n_start, 8'h01)
        `CHK(got_q.size(), 0)
        // repeated start closes the first message and opens a second
        clear();
        fill(2);
        host.start_cond();
        host.put_byte({own_addr, 1'b0});
        host.put_byte(tx_q[0]);
        host.start_cond();
        host.put_byte({own_addr, 1'b0});
        host.put_byte(tx_q[1]);
        host.stop_cond();
        repeat (8) @(negedge clk_sys);
        `CHK(n_start, 8'h02)
        `CHK(n_stop, 8'h02)
        `CHK(n_ctrl, 8'h02)
        `CHK(got_q.size(), 2)
        foreach (tx_q[i]) `CHK(got_q[i], tx_q[i])
        wrap_up();
    end
endmodule

`default_nettype wire

/* verification/ufmr_host.sv */
// behavioural host driving clock and data of the receive-only bus
`timescale 1ns/1ps
`default_nettype none

module ufmr_host (
    output logic usda,
    output logic uscl
);
    // both lines stand high outside frames
    initial begin
        usda = 1'b1;
        uscl = 1'b1;
    end

    task automatic start_cond();
        #62.5 usda = 1'b0;
        #62.5;
    endtask

    // data moves only in the low phase, one bit per pulse
    task automatic put_bit(input logic b);
        uscl = 1'b0;
        #31.25 usda = b;
        #31.25 uscl = 1'b1;
        #62.5;
    endtask

    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        put_bit(1'b1);
    endtask

    task automatic stop_cond();
        uscl = 1'b0;
        #31.25 usda = 1'b0;
        #31.25 uscl = 1'b1;
        #62.5 usda = 1'b1;
        #62.5;
    endtask
endmodule

`default_nettype wire
